// *** rtl/flash_ctrl_regs.vh ***
// flash_ctrl_regs.vh: register map, command codes and timing counts.
// parallel flash controller. assumes a 125 MHz system clock.
`ifndef FLASH_CTRL_REGS_VH
`define FLASH_CTRL_REGS_VH

// axi4-lite register byte offsets
`define REG_CTRL 6'h00
`define REG_ADDR 6'h04
`define REG_WDATA 6'h08
`define REG_STATUS 6'h0C
`define REG_RDATA 6'h10
`define REG_HVCTRL 6'h14

// ctrl fields
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 4
`define CTRL_OP_MSB 7
`define CTRL_RST_BIT 8
`define CTRL_BUSYWAIT_BIT 9

// operation codes
`define OP_READ 4'h0
`define OP_RESET1 4'h1
`define OP_RESET2 4'h2
`define OP_PROGRAM 4'h3
`define OP_CHIP_ERASE 4'h4
`define OP_SECTOR_ERASE 4'h5
`define OP_SECTOR_MORE 4'h6
`define OP_ID_ENTER 4'h7
`define OP_RAW_WRITE 4'h8

// status fields
`define STAT_BUSY_BIT 0
`define STAT_READY_BIT 1
`define STAT_BADOP_BIT 2

// hvctrl fields: requests for elevated voltage drivers on the board
`define HV_ID_BIT 0
`define HV_CS_BIT 1
`define HV_OE_BIT 2
`define HV_RST_BIT 3

// unlock and command bytes
`define UNLOCK_ADDR1 20'h0_0555
`define UNLOCK_ADDR2 20'h0_02AA
`define UNLOCK_DATA1 8'hAA
`define UNLOCK_DATA2 8'h55
`define CMD_RESET 8'hF0
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_ID 8'h90

// reset values
`define CTRL_RESET 32'h0000_0000
`define HVCTRL_RESET 4'h0

// timing, in ns, and derived cycle counts at 8 ns
`define CLK_PERIOD_NS 8
`define IDLE_RESET_TIME_NS 500
`define RESET_RECOVERY_TIME_NS 50
`define READY_WAIT_TIME_NS 20000
`define ACCESS_TIME_NS 70
`define WRITE_PULSE_NS 40
`define IDLE_RESET_CYC ((`IDLE_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVERY_CYC ((`RESET_RECOVERY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_WAIT_CYC ((`READY_WAIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/flash_bus_cycle.v ***
// flash_bus_cycle.v: one read or write cycle on the flash pins.
// assumes the caller holds addr/data/kind steady while start is seen once.
`default_nettype none
`include "flash_ctrl_regs.vh"

module flash_bus_cycle #(
  parameter ACCESS_CYC = `ACCESS_CYC,
  parameter PULSE_CYC = `WRITE_PULSE_CYC
) (
  // clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // request
  input wire start_i,
  input wire is_write_i,
  input wire [19:0] addr_i,
  input wire [7:0] wdata_i,
  output reg done_o,
  output reg [7:0] rdata_o,
  // pins
  output reg [19:0] addr_pin_o,
  output reg cs_n_o,
  output reg oe_n_o,
  output reg we_n_o,
  output reg [7:0] dq_out_o,
  output reg dq_oe_o,
  input wire [7:0] dq_in_i
);

  localparam S_IDLE = 4'b0001;
  localparam S_SETUP = 4'b0010;
  localparam S_STROBE = 4'b0100;
  localparam S_HOLD = 4'b1000;

  reg [3:0] state_ff;
  reg [7:0] cnt_ff;
  reg wr_ff;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      addr_pin_o <= 20'h0_0000;
      cs_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      dq_out_o <= 8'h00;
      dq_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (start_i) begin
            // address settles before any strobe falls
            addr_pin_o <= addr_i;
            wr_ff <= is_write_i;
            dq_out_o <= wdata_i;
            dq_oe_o <= is_write_i;
            state_ff <= S_SETUP;
          end
        end
        S_SETUP: begin
          cs_n_o <= 1'b0;
          oe_n_o <= wr_ff;
          we_n_o <= ~wr_ff;
          cnt_ff <= wr_ff ? PULSE_CYC[7:0] : ACCESS_CYC[7:0];
          state_ff <= S_STROBE;
        end
        S_STROBE: begin
          if (cnt_ff <= 8'h01) begin
            // we rises first, cs next cycle: data latched on the earlier edge
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            if (!wr_ff) begin
              rdata_o <= dq_in_i;
            end
            state_ff <= S_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        S_HOLD: begin
          cs_n_o <= 1'b1;
          dq_oe_o <= 1'b0;
          done_o <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule // flash_bus_cycle
`default_nettype wire

// *** rtl/flash_host_ctrl.v ***
// flash_host_ctrl.v: host-side controller for a byte-wide parallel flash, axi4-lite slave.
// assumes axi master keeps at most one read and one write outstanding.
//
// Operation
// - reset while busy: longer of ready wait, recovery.
// - reset while idle: pulse time, then recovery wait.
// - elevated voltage on id line and cs and/or oe.
// - protect every group before first unprotect.
// - program: two unlocks, command, data write.
// - erase: four unlocks, command, data writes.
// - id entry: two unlocks and command.
// - read/reset: command, or two unlocks and command.
// - address on later falling edge, data on earlier rising.
// - read: cs, oe low; write: cs, we low.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
`include "flash_ctrl_regs.vh"

module flash_host_ctrl #(
  parameter READY_WAIT_CYC = `READY_WAIT_CYC
) (
  // clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // axi4-lite write
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // flash pins
  output wire [19:0] addr_pin_o,
  output wire cs_n_o,
  output wire oe_n_o,
  output wire we_n_o,
  output reg flash_reset_n_o,
  output wire [7:0] dq_out_o,
  output wire dq_oe_o,
  input wire [7:0] dq_in_i,
  input wire op_done_pin_n_i,
  // elevated voltage driver requests
  output reg elevated_id_voltage_o,
  output reg hv_cs_o,
  output reg hv_oe_o,
  output reg hv_reset_o
);

  localparam S_IDLE = 6'b000001;
  localparam S_RST = 6'b000010;
  localparam S_RECOV = 6'b000100;
  localparam S_SEQ = 6'b001000;
  localparam S_WAIT = 6'b010000;
  localparam S_DONE = 6'b100000;

  localparam [15:0] IDLE_RESET_C = `IDLE_RESET_CYC;
  localparam [15:0] RECOVERY_C = `RECOVERY_CYC;
  localparam [15:0] READY_C = READY_WAIT_CYC;

  reg [5:0] state_ff;
  reg [15:0] cnt_ff;
  reg [3:0] op_ff;
  reg busywait_ff;
  reg [19:0] addr_ff;
  reg [7:0] wdata_ff;
  reg [7:0] rdata_ff;
  reg [2:0] step_ff;
  reg cyc_start_ff;
  reg cyc_pend_ff;
  reg badop_ff;
  reg reset_was_busy_ff;
  reg [15:0] ready_cnt_ff;
  reg [3:0] hv_ff;

  wire cyc_done;
  wire [7:0] cyc_rdata;
  reg [2:0] steps_total;
  reg [19:0] step_addr;
  reg [7:0] step_data;
  reg step_is_write;

  ////////////////////////////////////////////////////////////////////////////
  // step index to write address/data
  always @* begin
    steps_total = 3'd1;
    step_addr = addr_ff;
    step_data = wdata_ff;
    step_is_write = 1'b1;
    case (op_ff)
      `OP_READ: begin
        step_is_write = 1'b0;
      end
      `OP_RESET1: begin
        step_data = `CMD_RESET;
      end
      `OP_RESET2, `OP_ID_ENTER, `OP_PROGRAM: begin
        steps_total = (op_ff == `OP_PROGRAM) ? 3'd4 : 3'd3;
        case (step_ff)
          3'd0: begin
            step_addr = `UNLOCK_ADDR1;
            step_data = `UNLOCK_DATA1;
          end
          3'd1: begin
            step_addr = `UNLOCK_ADDR2;
            step_data = `UNLOCK_DATA2;
          end
          3'd2: begin
            step_addr = `UNLOCK_ADDR1;
            step_data = (op_ff == `OP_RESET2) ? `CMD_RESET :
                        (op_ff == `OP_ID_ENTER) ? `CMD_ID : `CMD_PROGRAM;
          end
          default: begin
          end
        endcase
      end
      `OP_CHIP_ERASE, `OP_SECTOR_ERASE: begin
        steps_total = 3'd6;
        case (step_ff)
          3'd0, 3'd3: begin
            step_addr = `UNLOCK_ADDR1;
            step_data = `UNLOCK_DATA1;
          end
          3'd1, 3'd4: begin
            step_addr = `UNLOCK_ADDR2;
            step_data = `UNLOCK_DATA2;
          end
          3'd2: begin
            step_addr = `UNLOCK_ADDR1;
            step_data = `CMD_ERASE_SETUP;
          end
          default: begin
            if (op_ff == `OP_CHIP_ERASE) begin
              step_addr = `UNLOCK_ADDR1;
              step_data = `CMD_CHIP_ERASE;
            end else begin
              step_data = `CMD_SECTOR_ERASE;
            end
          end
        endcase
      end
      `OP_SECTOR_MORE: begin
        step_data = `CMD_SECTOR_ERASE;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  flash_bus_cycle u_cycle (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .start_i(cyc_start_ff),
    .is_write_i(step_is_write),
    .addr_i(step_addr),
    .wdata_i(step_data),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .addr_pin_o(addr_pin_o),
    .cs_n_o(cs_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .dq_out_o(dq_out_o),
    .dq_oe_o(dq_oe_o),
    .dq_in_i(dq_in_i)
  );

  wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire busy = (state_ff != S_IDLE);
  wire go_wr = aw_take && (s_axi_awaddr == `REG_CTRL) && s_axi_wstrb[0] &&
               s_axi_wdata[`CTRL_GO_BIT] && !busy;
  wire rst_wr = aw_take && (s_axi_awaddr == `REG_CTRL) && s_axi_wstrb[1] &&
                s_axi_wdata[`CTRL_RST_BIT] && !busy;

  ////////////////////////////////////////////////////////////////////////////
  // axi slave and register file
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
      addr_ff <= 20'h0_0000;
      wdata_ff <= 8'h00;
      hv_ff <= `HVCTRL_RESET;
    end else begin
      s_axi_awready <= aw_take;
      s_axi_wready <= aw_take;
      if (aw_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (s_axi_awaddr)
          `REG_CTRL: begin
          end
          `REG_ADDR: begin
            if (!busy) addr_ff <= s_axi_wdata[19:0];
          end
          `REG_WDATA: begin
            if (!busy && s_axi_wstrb[0]) wdata_ff <= s_axi_wdata[7:0];
          end
          `REG_HVCTRL: begin
            if (s_axi_wstrb[0]) hv_ff <= s_axi_wdata[3:0];
          end
          `REG_STATUS, `REG_RDATA: begin
          end
          default: begin
            s_axi_bresp <= 2'b10;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= {22'h0, busywait_ff, 1'b0, op_ff, 4'h0};
          `REG_ADDR: s_axi_rdata <= {12'h000, addr_ff};
          `REG_WDATA: s_axi_rdata <= {24'h00_0000, wdata_ff};
          `REG_STATUS: s_axi_rdata <= {29'h0, badop_ff, op_done_pin_n_i, busy};
          `REG_RDATA: s_axi_rdata <= {24'h00_0000, rdata_ff};
          `REG_HVCTRL: s_axi_rdata <= {28'h000_0000, hv_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one go runs one command sequence
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 16'h0000;
      op_ff <= `OP_READ;
      busywait_ff <= 1'b0;
      step_ff <= 3'd0;
      cyc_start_ff <= 1'b0;
      cyc_pend_ff <= 1'b0;
      badop_ff <= 1'b0;
      rdata_ff <= 8'h00;
      reset_was_busy_ff <= 1'b0;
      ready_cnt_ff <= 16'h0000;
      flash_reset_n_o <= 1'b1;
      elevated_id_voltage_o <= 1'b0;
      hv_cs_o <= 1'b0;
      hv_oe_o <= 1'b0;
      hv_reset_o <= 1'b0;
    end else begin
      cyc_start_ff <= 1'b0;
      elevated_id_voltage_o <= hv_ff[`HV_ID_BIT];
      hv_cs_o <= hv_ff[`HV_CS_BIT];
      hv_oe_o <= hv_ff[`HV_OE_BIT];
      hv_reset_o <= hv_ff[`HV_RST_BIT];
      case (state_ff)
        S_IDLE: begin
          if (rst_wr) begin
            reset_was_busy_ff <= ~op_done_pin_n_i;
            flash_reset_n_o <= 1'b0;
            cnt_ff <= IDLE_RESET_C;
            ready_cnt_ff <= READY_C;
            state_ff <= S_RST;
          end else if (go_wr) begin
            op_ff <= s_axi_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
            busywait_ff <= s_axi_wdata[`CTRL_BUSYWAIT_BIT];
            badop_ff <= (s_axi_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB] > `OP_RAW_WRITE);
            step_ff <= 3'd0;
            cyc_pend_ff <= 1'b0;
            state_ff <= (s_axi_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB] > `OP_RAW_WRITE) ?
                        S_IDLE : S_SEQ;
          end
        end
        S_RST: begin
          if (ready_cnt_ff != 16'h0000) ready_cnt_ff <= ready_cnt_ff - 16'h0001;
          if (cnt_ff <= 16'h0001) begin
            flash_reset_n_o <= 1'b1;
            cnt_ff <= RECOVERY_C;
            state_ff <= S_RECOV;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        S_RECOV: begin
          if (ready_cnt_ff != 16'h0000) ready_cnt_ff <= ready_cnt_ff - 16'h0001;
          if (cnt_ff > 16'h0001) begin
            cnt_ff <= cnt_ff - 16'h0001;
          end else if (!reset_was_busy_ff || ready_cnt_ff <= 16'h0001) begin
            state_ff <= S_DONE;
          end
        end
        S_SEQ: begin
          if (!cyc_pend_ff) begin
            cyc_start_ff <= 1'b1;
            cyc_pend_ff <= 1'b1;
          end else if (cyc_done) begin
            cyc_pend_ff <= 1'b0;
            if (op_ff == `OP_READ) rdata_ff <= cyc_rdata;
            if (step_ff + 3'd1 >= steps_total) begin
              state_ff <= busywait_ff ? S_WAIT : S_DONE;
            end else begin
              step_ff <= step_ff + 3'd1;
            end
          end
        end
        S_WAIT: begin
          // done as soon as the busy pin reads high; a pin that lags the last write is not waited for
          if (op_done_pin_n_i) state_ff <= S_DONE;
        end
        S_DONE: begin
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule // flash_host_ctrl
`default_nettype wire

// *** testbench/flash_host_ctrl_sva.sv ***
// flash_host_ctrl_sva.sv: pin timing checks for the flash controller.
// assumes binding to flash_host_ctrl, seeing only its ports.
`default_nettype none
module flash_host_ctrl_sva #(
  parameter READY_WAIT_CYC = 2500
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // flash pins
  input wire logic [19:0] addr_pin_o,
  input wire logic cs_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic flash_reset_n_o,
  input wire logic [7:0] dq_out_o,
  input wire logic dq_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // saturates so a long low pulse cannot wrap back to a count under 63 that reads as too short
  logic [6:0] low_cnt_ff;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) low_cnt_ff <= 7'h00;
    else if (flash_reset_n_o) low_cnt_ff <= 7'h00;
    else if (low_cnt_ff != 7'h7F) low_cnt_ff <= low_cnt_ff + 7'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_WR_PULSE: assert property ($fell(we_n_o) |-> !we_n_o [*5] ##1 we_n_o)
    else $error("bad we width");
  AST_RD_PULSE: assert property ($fell(oe_n_o) |-> !oe_n_o [*8] ##1 !oe_n_o ##1 oe_n_o)
    else $error("bad oe width");
  AST_CS_AFTER: assert property ($rose(we_n_o) || $rose(oe_n_o) |->
    !cs_n_o ##1 (cs_n_o && !dq_oe_o)) else $error("cs held");
  AST_WR_HOLD: assert property (!we_n_o && !$past(we_n_o) |->
    dq_oe_o && $stable(dq_out_o) && $stable(addr_pin_o)) else $error("write data moved");
  AST_RD_FLOAT: assert property (!oe_n_o |-> !cs_n_o && we_n_o && !dq_oe_o)
    else $error("bad read levels");
  AST_WE_CS: assert property (!we_n_o |-> !cs_n_o && oe_n_o)
    else $error("bad write levels");
  AST_RST_QUIET: assert property (!flash_reset_n_o |-> cs_n_o && we_n_o && oe_n_o && !dq_oe_o)
    else $error("access in reset");
  AST_RST_WIDTH: assert property ($rose(flash_reset_n_o) |-> low_cnt_ff >= 7'd63)
    else $error("reset too short");
  AST_RST_RECOVER: assert property ($rose(flash_reset_n_o) |-> cs_n_o [*7])
    else $error("early access");
  cover property ($fell(we_n_o));
  cover property ($fell(oe_n_o));
  cover property ($rose(flash_reset_n_o));
endmodule // flash_host_ctrl_sva

bind flash_host_ctrl flash_host_ctrl_sva #(.READY_WAIT_CYC(READY_WAIT_CYC)) u_sva (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_pin_o(addr_pin_o), .cs_n_o(cs_n_o),
  .oe_n_o(oe_n_o), .we_n_o(we_n_o), .flash_reset_n_o(flash_reset_n_o),
  .dq_out_o(dq_out_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

// *** testbench/flash_model.sv ***
// flash_model.sv: behavioural byte-wide flash on the controller's pins.
// assumes registered strobes and board-level elevated voltage requests.
`default_nettype none
`include "flash_ctrl_regs.vh"
module flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h96, // arbitrary value
  parameter int BUSY_CYC = 30
) (
  // pins
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [19:0] addr_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic op_done_pin_n_o,
  // elevated voltage levels
  input wire logic id_hv_i,
  input wire logic cs_hv_i,
  input wire logic oe_hv_i,
  input wire logic rst_hv_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] prot = 8'h00;
  logic [2:0] step = 3'd0;
  logic id_mode = 1'b0;
  int busy = 0;
  logic [7:0] rd_val;
  wire rd = reset_n_i && !cs_n_i && !oe_n_i && we_n_i;
  assign op_done_pin_n_o = (busy == 0);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic command(input logic [19:0] a, input logic [7:0] d);
    logic u1;
    u1 = (a == `UNLOCK_ADDR1);
    if (d == `CMD_RESET) begin
      step = 3'd0;
      id_mode = 1'b0;
    end else begin
      case (step)
        0, 4: step = (u1 && d == `UNLOCK_DATA1) ? step + 3'd1 : 3'd0;
        1, 5: step = (a == `UNLOCK_ADDR2 && d == `UNLOCK_DATA2) ? step + 3'd1 : 3'd0;
        2: begin
          if (u1 && d == `CMD_ID) id_mode = 1'b1;
          step = !u1 ? 3'd0 : d == `CMD_PROGRAM ? 3'd3 : d == `CMD_ERASE_SETUP ? 3'd4 : 3'd0;
        end
        3: begin
          if (!prot[a[19:17]] || rst_hv_i) mem[a[7:0]] = mem[a[7:0]] & d;
          busy = BUSY_CYC;
          step = 3'd0;
        end
        6: begin
          if (d == `CMD_CHIP_ERASE || d == `CMD_SECTOR_ERASE) busy = BUSY_CYC;
          step = 3'd0;
        end
        default: step = 3'd0;
      endcase
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    dq_o = 8'h00;
  end
  always @(negedge reset_n_i) begin
    step = 3'd0;
    id_mode = 1'b0;
    busy = 0;
  end
  always @(posedge clock_i) if (busy != 0) busy <= busy - 1;
  // data taken at the strobe's rising edge, address still held then
  always @(posedge we_n_i) begin
    if (reset_n_i && !cs_n_i && oe_n_i) begin
      if (id_hv_i && oe_hv_i) begin
        if (!cs_hv_i) prot[addr_i[19:17]] = 1'b1;
        else if (&prot) prot = 8'h00;
      end else if (busy == 0) begin
        command(addr_i, dq_i);
      end
    end
  end
  always @* begin
    rd_val = mem[addr_i[7:0]];
    if (id_mode || id_hv_i) begin
      case (addr_i[7:0])
        8'h00: rd_val = MAKER_CODE;
        8'h01: rd_val = DEVICE_CODE;
        8'h02: rd_val = {7'h00, prot[addr_i[19:17]]};
        default: ;
      endcase
    end
  end
  // released bus toggles so a stale byte never reads as valid
  always @(posedge clock_i) dq_o <= rd ? rd_val : ~dq_o;
endmodule // flash_model
`default_nettype wire

// *** testbench/flash_host_ctrl_tb_top.sv ***
// flash_host_ctrl_tb_top.sv: self-checking bench for the flash controller.
// assumes flash_model on the pins.
`default_nettype none
`include "flash_ctrl_regs.vh"
module flash_host_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RW = 100;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] DEVICE = 8'h96; // arbitrary value
  logic clock_i, reset_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [19:0] addr_pin_o;
  logic cs_n_o, oe_n_o, we_n_o, flash_reset_n_o, dq_oe_o, op_done_pin_n_i;
  logic elevated_id_voltage_o, hv_cs_o, hv_oe_o, hv_reset_o;
  logic [7:0] dq_out_o, dq_in_i;
  int mismatches = 0;
  int n_compared = 0;
  flash_host_ctrl #(.READY_WAIT_CYC(RW)) dut (.clock_i, .reset_n_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addr_pin_o, .cs_n_o, .oe_n_o,
    .we_n_o, .flash_reset_n_o, .dq_out_o, .dq_oe_o, .dq_in_i, .op_done_pin_n_i,
    .elevated_id_voltage_o, .hv_cs_o, .hv_oe_o, .hv_reset_o);
  flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash (.clock_i,
    .reset_n_i(flash_reset_n_o), .addr_i(addr_pin_o), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o),
    .we_n_i(we_n_o), .dq_i(dq_out_o), .dq_o(dq_in_i), .op_done_pin_n_o(op_done_pin_n_i),
    .id_hv_i(elevated_id_voltage_o), .cs_hv_i(hv_cs_o), .oe_hv_i(hv_oe_o), .rst_hv_i(hv_reset_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 300) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_i);
      guard(++n);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_i);
      guard(++n);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // hi is {busy wait, flash reset}; cyc spans the control write to idle status
  task automatic run_op(input logic [3:0] op, input logic [19:0] a, input logic [7:0] d,
                        input logic [1:0] hi, output int cyc);
    logic [1:0] r;
    logic [31:0] s;
    int n = 0;
    time t0;
    axi_wr(`REG_ADDR, {12'h000, a}, r);
    axi_wr(`REG_WDATA, {24'h00_0000, d}, r);
    t0 = $time;
    axi_wr(`REG_CTRL, {22'h00_0000, hi, op, 4'h1}, r);
    do begin
      axi_rd(`REG_STATUS, s, r);
      guard(++n);
    end while (s[`STAT_BUSY_BIT] !== 1'b0);
    cyc = int'(($time - t0) / 8);
  endtask
  task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [7:0] d);
    int c;
    run_op(o, a, d, 2'b10, c);
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    op(`OP_READ, a, 8'h00);
    axi_rd(`REG_RDATA, v, r);
    check({24'h00_0000, v[7:0]}, {24'h00_0000, exp});
  endtask
  task automatic hv(input logic [3:0] v);
    logic [1:0] r;
    axi_wr(`REG_HVCTRL, {28'h000_0000, v}, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(`REG_CTRL, v, r);
    check(v, `CTRL_RESET);
    axi_rd(`REG_HVCTRL, v, r);
    check(v, 32'h0000_0000);
    axi_rd(6'h3C, v, r);
    check({30'h0, r}, 32'h0000_0002);
    axi_wr(6'h38, 32'h0000_0000, r);
    check({30'h0, r}, 32'h0000_0002);
    axi_wr(`REG_CTRL, 32'h0000_0091, r);
    axi_rd(`REG_STATUS, v, r);
    check({31'h0, v[`STAT_BADOP_BIT]}, 32'h0000_0001);
  endtask
  task automatic s_program();
    int c;
    rd_chk(20'h0_0012, 8'hFF);
    run_op(`OP_PROGRAM, 20'h0_0012, 8'h5A, 2'b10, c);
    check({31'h0, c >= 30}, 32'h0000_0001);
    rd_chk(20'h0_0012, 8'h5A);
    op(`OP_CHIP_ERASE, 20'h0_0000, 8'h00);
    op(`OP_SECTOR_ERASE, 20'h2_0000, 8'h00);
    op(`OP_SECTOR_MORE, 20'h4_0000, 8'h00);
  endtask
  task automatic s_id();
    op(`OP_ID_ENTER, 20'h0_0000, 8'h00);
    rd_chk(20'h1_2300, MAKER);
    rd_chk(20'hA_BC01, DEVICE);
    rd_chk(20'h2_0002, 8'h00);
    op(`OP_RESET2, 20'h0_0000, 8'h00);
    rd_chk(20'h0_0012, 8'h5A);
    op(`OP_ID_ENTER, 20'h0_0000, 8'h00);
    op(`OP_RESET1, 20'h0_0000, 8'h00);
    rd_chk(20'h0_0001, 8'hFF);
    hv(4'h1);
    rd_chk(20'h0_0001, DEVICE);
    hv(4'h0);
    rd_chk(20'h0_0001, 8'hFF);
  endtask
  task automatic s_protect();
    hv(4'h5);
    op(`OP_RAW_WRITE, 20'h6_0000, 8'h00);
    hv(4'h0);
    op(`OP_PROGRAM, 20'h6_0010, 8'h00);
    rd_chk(20'h6_0010, 8'hFF);
    op(`OP_ID_ENTER, 20'h0_0000, 8'h00);
    rd_chk(20'h6_0002, 8'h01);
    rd_chk(20'h4_0002, 8'h00);
    op(`OP_RESET1, 20'h0_0000, 8'h00);
    hv(4'h8);
    op(`OP_PROGRAM, 20'h6_0010, 8'h0F);
    rd_chk(20'h6_0010, 8'h0F);
    hv(4'h0);
    op(`OP_PROGRAM, 20'h6_0010, 8'h00);
    rd_chk(20'h6_0010, 8'h0F);
  endtask
  task automatic s_abort();
    logic [27:0] seq [12];
    seq = '{28'h005_55AA, 28'h002_AA55, 28'h005_55A0, 28'h005_55F0, 28'h000_2000,
            28'h005_55AA, 28'h001_2377, 28'h005_5590, 28'h005_55AA, 28'h002_AA55,
            28'h005_55F0, 28'h005_5590};
    foreach (seq[i]) op(`OP_RAW_WRITE, seq[i][27:8], seq[i][7:0]);
    rd_chk(20'h0_0020, 8'hFF);
    rd_chk(20'h0_0001, 8'hFF);
  endtask
  task automatic s_reset();
    int c;
    run_op(`OP_PROGRAM, 20'h0_0030, 8'h11, 2'b00, c);
    run_op(`OP_READ, 20'h0_0000, 8'h00, 2'b01, c);
    check({31'h0, c >= RW}, 32'h0000_0001);
    op(`OP_ID_ENTER, 20'h0_0000, 8'h00);
    run_op(`OP_READ, 20'h0_0000, 8'h00, 2'b01, c);
    check({31'h0, c >= 70 && c < RW}, 32'h0000_0001);
    rd_chk(20'h0_0001, 8'hFF);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial begin
    {reset_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h000_0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    s_regs();
    s_program();
    s_id();
    s_protect();
    s_abort();
    s_reset();
    summarize();
  end
endmodule // flash_host_ctrl_tb_top
`default_nettype wire
